// >>> hw/mms_pkg.sv
// mms_pkg: constants and types for the motion mode sequencer with dwell.
// assumes a single 50 MHz clock; commands arrive pre-decoded from a fetch unit.
package mms_pkg;

   // ************************************************************
   // command codes delivered by the block fetch unit
   // ************************************************************
   typedef enum logic [4:0] {
      mms_op_none = 5'h00,
      mms_op_point_to_point = 5'h01,
      mms_op_linear_interp = 5'h02,
      mms_op_arc_cw = 5'h03,
      mms_op_arc_ccw = 5'h04,
      mms_op_traverse = 5'h05,
      mms_op_dwell = 5'h06,
      mms_op_blend_mode = 5'h07,
      mms_op_halt_mode = 5'h08,
      mms_op_no_inpos_check = 5'h09,
      mms_op_ref_origin_return = 5'h0a,
      mms_op_work_origin_return = 5'h0b,
      mms_op_origin_search = 5'h0c,
      mms_op_origin_undefine = 5'h0d,
      mms_op_speed_control = 5'h0e,
      mms_op_interrupt_feed = 5'h0f,
      mms_op_coord_pv_change = 5'h10,
      mms_op_program_end = 5'h11,
      mms_op_aux_code = 5'h12,
      mms_op_data_code = 5'h13,
      mms_op_other = 5'h14
   } mms_op_t;

   // ************************************************************
   // operating modes and operand sources
   // ************************************************************
   typedef enum logic [1:0] {
      mms_mode_blend = 2'h0,
      mms_mode_halt = 2'h1,
      mms_mode_no_check = 2'h2
   } mms_mode_t;

   typedef enum logic [1:0] {
      mms_src_immediate = 2'h0,
      mms_src_register = 2'h1,
      mms_src_position = 2'h2
   } mms_src_t;

   // sequencer states, one-hot
   typedef enum logic [4:0] {
      mms_st_fetch = 5'h01,
      mms_st_wait_motion = 5'h02,
      mms_st_wait_stop = 5'h04,
      mms_st_dwell = 5'h08,
      mms_st_error = 5'h10
   } mms_state_t;

   // ************************************************************
   // field widths, operand ranges, timing
   // ************************************************************
   localparam int MMS_BLK_W = 16; // block number width
   localparam int MMS_REG_IDX_W = 5; // numeric register index
   localparam int MMS_POS_IDX_W = 11; // position data address
   localparam logic [4:0] MMS_FIRST_NUMERIC_REGISTER = 5'h00;
   localparam logic [4:0] MMS_LAST_NUMERIC_REGISTER = 5'h1f;
   localparam logic [10:0] MMS_FIRST_POSITION_DATA_ADDR = 11'h000;
   localparam logic [10:0] MMS_LAST_POSITION_DATA_ADDR = 11'h7cf;
   localparam logic [9:0] MMS_LAST_STOP_AUX_CODE = 10'h1f3;
   // wait time carried in units of 0.0001 s (four fraction digits)
   localparam int MMS_TIME_W = 32;
   localparam logic [31:0] MMS_TIME_MIN_MS = 32'h0000_000a; // 0.001 s
   localparam logic [31:0] MMS_TIME_MAX_MS = 32'h17d7_83c4; // 39999.994 s
   localparam logic [31:0] MMS_ROUND_HALF = 32'h0000_0005;
   localparam logic [31:0] MMS_ROUND_DIV = 32'h0000_000a;
   localparam int MMS_CLK_HZ = 50_000_000;
   localparam int MMS_TICK_MS = 20; // timer tick 0.02 s
   localparam int MMS_TICK_CYC = MMS_CLK_HZ / 1000 * MMS_TICK_MS;
   localparam int MMS_TICK_W = 20;

endpackage : mms_pkg

// >>> hw/mms_sequencer.sv
// mms_sequencer: mode selection, look-ahead and dwell timing for one task.
// assumes a fetch unit presenting one decoded block at a time with a
// valid/accept handshake, axis engines answering with motion done.
`timescale 1ns/1ns
`default_nettype none

module mms_sequencer
   import mms_pkg::*;
#(
   // sim may shorten the 0.02 s tick (1,000,000 cycles by default)
   parameter int TICK_CYC = mms_pkg::MMS_TICK_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // decoded block from fetch unit
   input wire logic blk_valid,
   input wire mms_pkg::mms_op_t blk_op,
   input wire logic [mms_pkg::MMS_BLK_W-1:0] blk_num,
   input wire logic blk_has_option,
   input wire logic blk_plane_changed,
   input wire logic blk_has_aux,
   input wire logic [9:0] blk_aux_code,
   input wire logic blk_tiny_move,
   input wire mms_pkg::mms_src_t dwell_src,
   input wire logic [mms_pkg::MMS_TIME_W-1:0] dwell_imm_ms,
   input wire logic [mms_pkg::MMS_REG_IDX_W-1:0] dwell_reg_idx,
   input wire logic [mms_pkg::MMS_POS_IDX_W-1:0] dwell_pos_idx,
   output logic blk_accept,
   // operand memory read port, one cycle latency, 0.00001 s units
   output logic op_rd_en,
   output logic op_rd_is_pos,
   output logic [mms_pkg::MMS_POS_IDX_W-1:0] op_rd_addr,
   input wire logic [mms_pkg::MMS_TIME_W-1:0] op_rd_data,
   // axis engines
   output logic move_start,
   output mms_pkg::mms_op_t move_op,
   output logic move_full_stop,
   input wire logic move_done,
   // host view
   output logic [mms_pkg::MMS_BLK_W-1:0] exec_blk_num,
   output mms_pkg::mms_mode_t op_mode,
   output logic seq_error
);

   // ************************************************************
   // state record
   // ************************************************************
   typedef struct packed {
      mms_state_t st; // sequencer state
      mms_mode_t mode; // current operating mode
      logic moving; // a motion is still in progress
      logic accept; // block taken this cycle
      logic rd_en; // operand read in flight
      logic rd_pend; // operand data valid this cycle
      logic rd_pos; // read aims at position data
      logic [MMS_POS_IDX_W-1:0] rd_addr; // operand address
      logic start; // move start pulse
      mms_op_t mop; // move kind
      logic full; // move ends in full stop
      logic [MMS_BLK_W-1:0] blk; // reported block number
      logic [MMS_TIME_W-1:0] ticks; // remaining timer ticks
      logic [MMS_TICK_W-1:0] div; // cycles within one tick
      logic err; // sticky range error
   } mms_reg_t;

   mms_reg_t r_q; // registered state
   mms_reg_t r_d; // next state

   // motion kinds that interpolate (blend candidates)
   function automatic logic is_interp(input mms_op_t op);
      return op == mms_op_linear_interp || op == mms_op_arc_cw ||
             op == mms_op_arc_ccw || op == mms_op_traverse;
   endfunction

   // origin commands reset the mode to blend
   function automatic logic is_origin(input mms_op_t op);
      return op == mms_op_ref_origin_return ||
             op == mms_op_work_origin_return ||
             op == mms_op_origin_search;
   endfunction

   // commands that pause look-ahead and force full stop
   function automatic logic is_barrier(input mms_op_t op);
      return op == mms_op_point_to_point || op == mms_op_dwell ||
             is_origin(op) || op == mms_op_origin_undefine ||
             op == mms_op_speed_control || op == mms_op_interrupt_feed ||
             op == mms_op_coord_pv_change || op == mms_op_program_end ||
             op == mms_op_aux_code || op == mms_op_data_code;
   endfunction

   // round raw 0.00001 s units to 0.0001 s at the fourth digit
   // one spare bit so a huge memory word cannot wrap into the legal range
   function automatic logic [MMS_TIME_W-1:0] round4(
      input logic [MMS_TIME_W-1:0] raw);
      logic [MMS_TIME_W:0] sum;
      sum = {1'b0, raw} + {1'b0, MMS_ROUND_HALF};
      return MMS_TIME_W'(sum / {1'b0, MMS_ROUND_DIV});
   endfunction

   // ticks needed: whole ticks in t plus one, so the wait is never short
   function automatic logic [MMS_TIME_W-1:0] to_ticks(
      input logic [MMS_TIME_W-1:0] t);
      return t / MMS_TIME_W'(MMS_TICK_MS * 10) + 32'h0000_0001;
   endfunction

   logic [MMS_TIME_W-1:0] wait_t; // rounded indirect wait time
   logic range_bad; // wait time outside the legal range
   logic stop_need; // incoming motion must end in full stop

   // ************************************************************
   // next-state logic
   // ************************************************************
   always_comb begin
      r_d = r_q;
      r_d.accept = 1'b0;
      r_d.start = 1'b0;
      r_d.rd_en = 1'b0;
      r_d.rd_pend = r_q.rd_en;
      wait_t = round4(op_rd_data);
      range_bad = (wait_t < MMS_TIME_MIN_MS) ||
                  (wait_t > MMS_TIME_MAX_MS);
      // a move is full stop unless blending is safe for this block
      stop_need = r_q.mode == mms_mode_halt || blk_has_option ||
                  blk_plane_changed || blk_tiny_move ||
                  (blk_has_aux &&
                   blk_aux_code <= MMS_LAST_STOP_AUX_CODE);
      // the engine reports completion of the move in flight
      if (move_done) begin
         r_d.moving = 1'b0;
      end
      case (r_q.st)
         mms_st_fetch: begin
            // a block still shown while accept is high was taken last edge
            if (blk_valid && !r_q.accept) begin
               if (is_interp(blk_op)) begin
                  // look-ahead stops at the next motion block
                  // no-check mode starts at once unless this move must stop
                  if (r_q.moving && !move_done &&
                      (r_q.mode != mms_mode_no_check || stop_need)) begin
                     r_d.st = mms_st_wait_motion;
                  end else begin
                     r_d.accept = 1'b1;
                     r_d.start = 1'b1;
                     r_d.mop = blk_op;
                     r_d.blk = blk_num;
                     // next block is dwell? the fetch unit flags it
                     // through tiny/option only, so dwell is handled
                     // by the barrier wait below instead
                     r_d.full = stop_need;
                     r_d.moving = 1'b1;
                     // a full-stop move waits for in-position in any mode
                     if (stop_need) begin
                        r_d.st = mms_st_wait_stop;
                     end
                  end
               end else if (is_barrier(blk_op) &&
                            r_q.moving && !move_done) begin
                  // moving axis must stop before this block runs
                  r_d.st = mms_st_wait_motion;
               end else begin
                  // non-motion block executes ahead, number reported
                  r_d.accept = 1'b1;
                  r_d.blk = blk_num;
                  case (blk_op)
                     mms_op_blend_mode: r_d.mode = mms_mode_blend;
                     mms_op_halt_mode: r_d.mode = mms_mode_halt;
                     mms_op_no_inpos_check: begin
                        r_d.mode = mms_mode_no_check;
                     end
                     mms_op_point_to_point: begin
                        r_d.start = 1'b1;
                        r_d.mop = blk_op;
                        r_d.full = 1'b1;
                        r_d.moving = 1'b1;
                        r_d.st = mms_st_wait_stop;
                     end
                     mms_op_dwell: begin
                        // immediate time goes straight to the check
                        r_d.rd_en = dwell_src != mms_src_immediate;
                        r_d.rd_pos = dwell_src == mms_src_position;
                        r_d.rd_addr = dwell_src == mms_src_position ?
                           dwell_pos_idx :
                           {6'h00, dwell_reg_idx};
                        r_d.st = mms_st_dwell;
                        r_d.ticks = to_ticks(dwell_imm_ms);
                        r_d.div = '0;
                        if (dwell_src == mms_src_immediate &&
                            (dwell_imm_ms < MMS_TIME_MIN_MS ||
                             dwell_imm_ms > MMS_TIME_MAX_MS)) begin
                           r_d.err = 1'b1;
                           r_d.st = mms_st_error;
                        end
                     end
                     default: begin
                        // origin commands restore blend mode
                        if (is_origin(blk_op)) begin
                           r_d.mode = mms_mode_blend;
                        end
                     end
                  endcase
               end
            end
         end
         mms_st_wait_motion: begin
            // look-ahead resumes when the move in flight completes
            if (!r_q.moving || move_done) begin
               r_d.st = mms_st_fetch;
            end
         end
         mms_st_wait_stop: begin
            // completion must be confirmed before the next block
            if (!r_q.moving || move_done) begin
               r_d.st = mms_st_fetch;
            end
         end
         mms_st_dwell: begin
            if (r_q.rd_pend) begin
               // indirect operand arrives now
               if (range_bad) begin
                  r_d.err = 1'b1;
                  r_d.st = mms_st_error;
               end else begin
                  r_d.ticks = to_ticks(wait_t);
               end
            end else if (!r_q.rd_en) begin
               if (r_q.div == MMS_TICK_W'(TICK_CYC - 1)) begin
                  r_d.div = '0;
                  r_d.ticks = r_q.ticks - 32'h0000_0001;
                  if (r_q.ticks == 32'h0000_0001) begin
                     r_d.st = mms_st_fetch;
                  end
               end else begin
                  r_d.div = r_q.div + MMS_TICK_W'(1);
               end
            end
         end
         mms_st_error: begin
            // program halted until reset
            r_d.err = 1'b1;
         end
         default: r_d.st = mms_st_fetch;
      endcase
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         r_q <= '{st: mms_st_fetch, mode: mms_mode_blend,
                  mop: mms_op_none, default: '0};
      end else begin
         r_q <= r_d;
      end
   end

   // outputs straight from flops
   assign blk_accept = r_q.accept;
   assign op_rd_en = r_q.rd_en;
   assign op_rd_is_pos = r_q.rd_pos;
   assign op_rd_addr = r_q.rd_addr;
   assign move_start = r_q.start;
   assign move_op = r_q.mop;
   assign move_full_stop = r_q.full;
   assign exec_blk_num = r_q.blk;
   assign op_mode = r_q.mode;
   assign seq_error = r_q.err;

endmodule // mms_sequencer

`default_nettype wire

// >>> tb/mms_axis_model.sv
// mms_axis_model: axis engines and operand memory for the sequencer.
// assumes moves finish in start order; done_dly sets the pace.
`timescale 1ns/1ns
`default_nettype none
module mms_axis_model
   import mms_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // requests from the sequencer
   input wire logic move_start,
   input wire logic op_rd_en,
   // bench settings
   input wire logic [7:0] done_dly,
   input wire logic [mms_pkg::MMS_TIME_W-1:0] mem_word,
   // answers
   output logic move_done,
   output logic [mms_pkg::MMS_TIME_W-1:0] op_rd_data
);
   logic [7:0] cnt_q; // cycles left on the oldest move
   logic [3:0] pend_q; // moves started, not yet reported
   logic rd_q; // a read was issued last cycle
   logic fire; // oldest move reaches position now
   assign fire = (pend_q != 4'h0) && (cnt_q == 8'h00);
   // outside a read cycle the bus shows the inverse word, never a copy
   assign op_rd_data = rd_q ? mem_word : ~mem_word;
   // one completion per done_dly+1 cycles; overlapping moves queue up
   always_ff @(posedge mclk) begin
      if (rst) begin
         {cnt_q, pend_q, rd_q, move_done} <= '0;
      end else begin
         rd_q <= op_rd_en;
         move_done <= fire;
         pend_q <= pend_q + {3'h0, move_start} - {3'h0, fire};
         if (fire || (move_start && pend_q == 4'h0)) begin
            cnt_q <= done_dly;
         end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
endmodule // mms_axis_model
`default_nettype wire

// >>> tb/mms_seq_checker.sv
// mms_seq_checker: port properties of the motion mode sequencer.
// assumes a bind onto mms_sequencer; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module mms_seq_checker
   import mms_pkg::*;
#(
   parameter int TICK_CYC = 10 // dwell tick, handed on by the bind
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // block side
   input wire mms_pkg::mms_op_t blk_op,
   input wire logic [mms_pkg::MMS_BLK_W-1:0] blk_num,
   input wire logic blk_has_aux,
   input wire logic [9:0] blk_aux_code,
   input wire logic blk_accept,
   // axis and host side
   input wire logic move_start,
   input wire logic move_full_stop,
   input wire logic [mms_pkg::MMS_BLK_W-1:0] exec_blk_num,
   input wire mms_pkg::mms_mode_t op_mode,
   input wire logic seq_error
);
   // ************************************************************
   // properties, one clock domain
   // ************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   property p_acc_pulse; blk_accept |=> !blk_accept; endproperty
   a_acc_pulse: assert property (p_acc_pulse)
      else $error("accept held over two cycles");
   property p_exec; blk_accept |-> exec_blk_num == $past(blk_num); endproperty
   a_exec: assert property (p_exec)
      else $error("reported block is not the accepted one");
   // mode only moves when a block is consumed
   property p_hold; !blk_accept |-> $stable(op_mode); endproperty
   a_hold: assert property (p_hold)
      else $error("mode changed without a block");
   property p_halt;
      blk_accept && $past(blk_op) == mms_op_halt_mode |-> op_mode == mms_mode_halt;
   endproperty
   a_halt: assert property (p_halt)
      else $error("halt command did not select halt mode");
   property p_origin;
      blk_accept && $past(blk_op) inside {mms_op_ref_origin_return,
         mms_op_work_origin_return, mms_op_origin_search}
         |-> op_mode == mms_mode_blend;
   endproperty
   a_origin: assert property (p_origin)
      else $error("origin command left mode unchanged");
   property p_nochk;
      blk_accept && $past(blk_op) == mms_op_no_inpos_check
         |-> op_mode == mms_mode_no_check;
   endproperty
   a_nochk: assert property (p_nochk)
      else $error("no-check command did not select its mode");
   property p_halt_fs;
      move_start && op_mode == mms_mode_halt |-> move_full_stop;
   endproperty
   a_halt_fs: assert property (p_halt_fs)
      else $error("move in halt mode without full stop");
   property p_aux_fs;
      move_start && $past(blk_has_aux)
         && $past(blk_aux_code) <= MMS_LAST_STOP_AUX_CODE |-> move_full_stop;
   endproperty
   a_aux_fs: assert property (p_aux_fs)
      else $error("low aux code move without full stop");
   property p_err_sticky; seq_error |=> seq_error; endproperty
   a_err_sticky: assert property (p_err_sticky)
      else $error("error flag dropped");
   property p_err_stop;
      seq_error |=> !blk_accept && !move_start;
   endproperty
   a_err_stop: assert property (p_err_stop)
      else $error("block consumed after error");
endmodule // mms_seq_checker
`default_nettype wire

// >>> tb/tb.sv
// tb: self-checking bench for mms_sequencer with the axis model.
// assumes a 50 MHz clock and a dwell tick shortened to 10 cycles.
`timescale 1ns/1ns
`default_nettype none
module tb;
   import mms_pkg::*;
   localparam int TICK = 10; // shortened 0.02 s tick
   logic mclk, rst, blk_valid, has_opt, plane_chg, has_aux, tiny;
   logic acc, rd_en, rd_pos, start, fs, done, err, st_s, fs_s, p_s;
   mms_op_t blk_op, mop, op_s;
   mms_src_t src;
   mms_mode_t mode;
   logic [15:0] blk_num, exec;
   logic [9:0] aux;
   logic [31:0] imm, mem_word, rd_data;
   logic [4:0] reg_idx;
   logic [10:0] pos_idx, rd_addr, a_s;
   logic [7:0] dly; // axis completion delay
   int n_fail, compares, n_done;
   mms_sequencer #(.TICK_CYC(TICK)) DUT (.mclk(mclk), .rst(rst),
      .blk_valid(blk_valid), .blk_op(blk_op), .blk_num(blk_num),
      .blk_has_option(has_opt), .blk_plane_changed(plane_chg),
      .blk_has_aux(has_aux), .blk_aux_code(aux), .blk_tiny_move(tiny),
      .dwell_src(src), .dwell_imm_ms(imm), .dwell_reg_idx(reg_idx),
      .dwell_pos_idx(pos_idx), .blk_accept(acc), .op_rd_en(rd_en),
      .op_rd_is_pos(rd_pos), .op_rd_addr(rd_addr), .op_rd_data(rd_data),
      .move_start(start), .move_op(mop), .move_full_stop(fs),
      .move_done(done), .exec_blk_num(exec), .op_mode(mode),
      .seq_error(err));
   mms_axis_model AX (.mclk(mclk), .rst(rst), .move_start(start),
      .op_rd_en(rd_en), .done_dly(dly), .mem_word(mem_word),
      .move_done(done), .op_rd_data(rd_data));
   // clock and completion count
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) if (done === 1'b1) n_done <= n_done + 1;
   // last operand read request, for the address checks
   always @(posedge mclk) if (rd_en === 1'b1) {p_s, a_s} <= {rd_pos, rd_addr};
   task automatic check(input string nm, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h seen %h", nm, e, s);
      end
   endtask
   // presents one block, waits for accept (bounded), then drops it
   task automatic send(input mms_op_t op, input logic [15:0] n,
                       output int w);
      blk_op <= op;
      blk_num <= n;
      blk_valid <= 1'b1;
      w = 0;
      do begin
         @(posedge mclk);
         w++;
      end while (acc !== 1'b1 && w < 400);
      check("accept", acc, 1'b1);
      st_s = start;
      fs_s = fs;
      op_s = mop;
      blk_valid <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      check("mode", mode, mms_mode_blend);
      check("error", err, 1'b0);
   endtask
   // look-ahead runs a plain block, stops at the next motion
   task automatic t_blend();
      int w, d0;
      send(mms_op_linear_interp, 16'h0001, w);
      check("fs", fs_s, 1'b0);
      d0 = n_done;
      send(mms_op_other, 16'h0002, w);
      check("ahead", n_done == d0, 1'b1);
      check("blk", exec, 16'h0002);
      send(mms_op_linear_interp, 16'h0003, w);
      check("held", n_done != d0, 1'b1);
   endtask
   task automatic t_halt();
      int w, d0;
      mms_op_t og[3] = '{mms_op_ref_origin_return,
         mms_op_work_origin_return, mms_op_origin_search};
      send(mms_op_halt_mode, 16'h0010, w);
      send(mms_op_linear_interp, 16'h0011, w);
      check("fs", fs_s, 1'b1);
      d0 = n_done;
      send(mms_op_other, 16'h0012, w);
      check("held", n_done != d0, 1'b1);
      check("mode", mode, mms_mode_halt);
      foreach (og[i]) begin
         send(mms_op_halt_mode, 16'h0013, w);
         send(og[i], 16'h0014, w);
         check("mode", mode, mms_mode_blend);
      end
   endtask
   task automatic t_nocheck();
      int w, d0;
      repeat (100) @(posedge mclk);
      send(mms_op_halt_mode, 16'h0015, w);
      send(mms_op_no_inpos_check, 16'h0016, w);
      send(mms_op_linear_interp, 16'h0017, w);
      check("fs", fs_s, 1'b0);
      d0 = n_done;
      send(mms_op_linear_interp, 16'h0018, w);
      check("early", n_done == d0 && st_s, 1'b1);
      send(mms_op_halt_mode, 16'h0019, w);
      check("mode", mode, mms_mode_halt);
      send(mms_op_no_inpos_check, 16'h001a, w);
      send(mms_op_blend_mode, 16'h001b, w);
      check("mode", mode, mms_mode_blend);
   endtask
   task automatic t_motion();
      int w;
      mms_op_t mv[4] = '{mms_op_traverse, mms_op_linear_interp,
         mms_op_arc_cw, mms_op_arc_ccw};
      foreach (mv[i]) begin
         send(mv[i], 16'h0020, w);
         check("fs", fs_s, 1'b0);
         check("op", op_s, mv[i]);
      end
      has_aux <= 1'b1;
      aux <= 10'h1f3;
      send(mms_op_linear_interp, 16'h0021, w);
      check("fs", fs_s, 1'b1);
      aux <= 10'h1f4;
      send(mms_op_linear_interp, 16'h0022, w);
      check("fs", fs_s, 1'b0);
      has_aux <= 1'b0;
      has_opt <= 1'b1;
      send(mms_op_linear_interp, 16'h0023, w);
      check("fs", fs_s, 1'b1);
      has_opt <= 1'b0;
   endtask
   // cycles from dwell to the next accept stay within lo..hi
   task automatic dwell(input mms_src_t s, input logic [31:0] t, m,
                        input int lo, hi);
      int w;
      logic [10:0] ea;
      src <= s;
      imm <= t;
      mem_word <= m;
      send(mms_op_dwell, 16'h0030, w);
      send(mms_op_other, 16'h0031, w);
      check("dwell_lo", w >= lo, 1'b1);
      check("dwell_hi", w <= hi, 1'b1);
      if (s != mms_src_immediate) begin
         ea = s == mms_src_position ? pos_idx : {6'h00, reg_idx};
         check("rd_pos", p_s, s == mms_src_position);
         check("rd_addr", a_s, ea);
      end
   endtask
   task automatic t_barrier();
      int w, d0;
      mms_op_t br[9] = '{mms_op_point_to_point, mms_op_dwell,
         mms_op_origin_undefine, mms_op_speed_control,
         mms_op_interrupt_feed, mms_op_coord_pv_change, mms_op_aux_code,
         mms_op_data_code, mms_op_program_end};
      src <= mms_src_immediate;
      imm <= 32'h0000_000a;
      foreach (br[i]) begin
         repeat (100) @(posedge mclk);
         send(mms_op_linear_interp, 16'h0040, w);
         d0 = n_done;
         send(br[i], 16'h0041, w);
         check("barrier", n_done != d0, 1'b1);
      end
   endtask
   // a bad wait time flags an error and nothing is consumed after it
   task automatic t_err(input mms_src_t s, input logic [31:0] t, m);
      int w;
      do_reset();
      src <= s;
      imm <= t;
      mem_word <= m;
      send(mms_op_dwell, 16'h0050, w);
      repeat (4) @(posedge mclk);
      check("error", err, 1'b1);
      blk_op <= mms_op_other;
      blk_num <= 16'h0051;
      blk_valid <= 1'b1;
      repeat (20) @(posedge mclk);
      check("stopped", exec, 16'h0050);
      blk_valid <= 1'b0;
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      {blk_valid, has_opt, plane_chg, has_aux, tiny} = '0;
      blk_op = mms_op_none;
      src = mms_src_immediate;
      {blk_num, aux, imm, mem_word, reg_idx, pos_idx} = '0;
      dly = 8'd30;
      @(posedge mclk);
      do_reset();
      t_blend();
      t_halt();
      t_nocheck();
      t_motion();
      dwell(mms_src_immediate, 32'd200, 32'd0, 18, 34);
      dwell(mms_src_immediate, 32'd10, 32'd0, 0, 14);
      check("error", err, 1'b0);
      reg_idx <= 5'h1f;
      dwell(mms_src_register, 32'd0, 32'd20000, 98, 114);
      pos_idx <= 11'h7cf;
      dwell(mms_src_position, 32'd0, 32'd19996, 98, 114);
      t_barrier();
      t_err(mms_src_immediate, 32'd0, 32'd0);
      t_err(mms_src_immediate, 32'd9, 32'd0);
      t_err(mms_src_immediate, 32'h17d7_83ce, 32'd0);
      t_err(mms_src_register, 32'd0, 32'hffff_ffff);
      test_done();
   end
   // hang guard, well beyond the longest expected run
   initial begin
      repeat (40000) @(posedge mclk);
      n_fail++;
      test_done();
   end
endmodule // tb
bind mms_sequencer mms_seq_checker #(.TICK_CYC(TICK_CYC)) u_chk (
   .mclk(mclk), .rst(rst), .blk_op(blk_op), .blk_num(blk_num),
   .blk_has_aux(blk_has_aux), .blk_aux_code(blk_aux_code),
   .blk_accept(blk_accept), .move_start(move_start),
   .move_full_stop(move_full_stop), .exec_blk_num(exec_blk_num),
   .op_mode(op_mode), .seq_error(seq_error));
`default_nettype wire
